// file: include/adc_acc_cfg.svh
// Constants of the converter result, accumulate and format block.
// Included by the package and the design; holds definitions only.
`ifndef ADC_ACC_CFG_SVH
`define ADC_ACC_CFG_SVH
// Repeat-count field codes
`define REPEAT_1 3'h0
`define REPEAT_4 3'h1
`define REPEAT_8 3'h2
`define REPEAT_16 3'h3
`define REPEAT_32 3'h4
`define REPEAT_64 3'h5
// Sample totals per series
`define TOTAL_1 7'h01
`define TOTAL_4 7'h04
`define TOTAL_8 7'h08
`define TOTAL_16 7'h10
`define TOTAL_32 7'h20
`define TOTAL_64 7'h40
// Justify and shift field codes
`define JUSTIFY_RIGHT 3'h0
`define JUSTIFY_LEFT 3'h4
`define JUSTIFY_LEFT_BIT 2
// Left justification moves a 10-bit code up by this many places
`define LEFT_JUSTIFY_SHIFT 6
// Low result byte value in 8-bit mode
`define LOW_BYTE_ZERO 8'h00
// Default converter power-up wait, in system clocks
`define POWERUP_CYCLES_DEFAULT 16
`endif

// file: include/adc_acc_pkg.sv
// Types shared by the converter result, accumulate and format block.
// Assumes the constants header is on the include path.
package adc_acc_pkg;
`include "adc_acc_cfg.svh"
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_POWERUP,
      ST_CONVERT
   } state_type;

   typedef struct packed {
      logic buffer_low_power_bit;
      logic [1:0] converter_bias_field;
      logic mux_low_power_bit;
   } power_cfg_type;

   typedef struct packed {
      logic [7:0] result_high_byte;
      logic [7:0] result_low_byte;
   } result_type;
endpackage

// file: src/adc_result_accumulate_format.sv
// Digital back end of a SAR converter: power gating, SAR clock divider,
// sample accumulation and result formatting.
// Assumes an analog core that starts on core_start and answers with core_done
// plus a 10-bit code; control bits come straight from software-owned ports.
`timescale 1ns/1ns
`include "adc_acc_cfg.svh"
module adc_result_accumulate_format
   import adc_acc_pkg::*;
#(
   parameter int POWERUP_CYCLES = `POWERUP_CYCLES_DEFAULT
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Control bits
   input wire logic converter_enable_bit,
   input wire logic burst_mode_enable_bit,
   input wire logic eight_bit_mode_bit,
   input wire logic internal_ref_select,
   input wire logic [2:0] repeat_count_field,
   input wire logic [2:0] justify_shift_field,
   input wire logic [4:0] sar_clock_divider_field,
   input wire power_cfg_type power_control_reg,
   // Events
   input wire logic convert_start,
   input wire logic done_flag_clear,
   // Analog core
   output logic core_start,
   input wire logic core_done,
   input wire logic [9:0] core_code,
   output logic core_power_on,
   output logic ref_power_on,
   output power_cfg_type core_power_cfg,
   output logic sar_clock_tick,
   // Status and result
   output logic busy,
   output logic conversion_done_flag,
   output result_type result_word
);
   logic [1:0] rst_sync_reg;
   logic rst_n;
   state_type state_reg;
   logic [15:0] acc_reg;
   logic [6:0] count_reg;
   logic [6:0] total_reg;
   logic [15:0] pu_cnt_reg;
   logic [4:0] div_cnt_reg;
   logic tick_reg;
   logic start_reg;
   logic flag_reg;
   result_type result_reg;
   power_cfg_type pcfg_reg;
   logic accept;
   logic need_powerup;
   logic pu_done;
   logic last_conv;
   logic launch;
   logic left_sel;
   logic [1:0] shift_amt;
   logic [9:0] sample;
   logic [15:0] sum_next;
   logic [15:0] formatted;
   logic [6:0] count_inc;

   function automatic logic [6:0] repeat_total(input logic [2:0] f);
      case (f)
         `REPEAT_4: repeat_total = `TOTAL_4;
         `REPEAT_8: repeat_total = `TOTAL_8;
         `REPEAT_16: repeat_total = `TOTAL_16;
         `REPEAT_32: repeat_total = `TOTAL_32;
         `REPEAT_64: repeat_total = `TOTAL_64;
         default: repeat_total = `TOTAL_1;
      endcase
   endfunction

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Starts arriving outside ST_IDLE (power-up or conversion running) are dropped, not queued
   assign accept = convert_start && (state_reg == ST_IDLE);
   assign need_powerup = burst_mode_enable_bit && !converter_enable_bit;
   assign pu_done = (state_reg == ST_POWERUP) && (pu_cnt_reg == 16'(POWERUP_CYCLES - 1));
   assign count_inc = count_reg + 7'h01;
   // flag only after the full count
   assign last_conv = (state_reg == ST_CONVERT) && core_done && (count_inc == total_reg);
   assign launch = (accept && !need_powerup) || pu_done
      || ((state_reg == ST_CONVERT) && core_done && !last_conv && burst_mode_enable_bit);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         pu_cnt_reg <= 16'h0000;
         start_reg <= 1'b0;
      end else begin
         start_reg <= launch;
         case (state_reg)
            ST_IDLE: begin
               pu_cnt_reg <= 16'h0000;
               if (accept) begin
                  state_reg <= need_powerup ? ST_POWERUP : ST_CONVERT;
               end
            end
            ST_POWERUP: begin
               pu_cnt_reg <= pu_cnt_reg + 16'h0001;
               if (pu_done) begin
                  state_reg <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (core_done && (last_conv || !burst_mode_enable_bit)) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // 8-bit mode drops the two LSBs
   assign sample = eight_bit_mode_bit ? {core_code[9:2], 2'h0} : core_code;
   assign sum_next = acc_reg + {6'h00, sample};

   // Non-burst series span several starts; count_reg marks the position
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= 16'h0000;
         count_reg <= 7'h00;
         total_reg <= `TOTAL_1;
      end else if (accept && (count_reg == 7'h00)) begin
         acc_reg <= 16'h0000;
         total_reg <= repeat_total(repeat_count_field);
      end else if ((state_reg == ST_CONVERT) && core_done) begin
         acc_reg <= last_conv ? 16'h0000 : sum_next;
         count_reg <= last_conv ? 7'h00 : count_inc;
      end
   end

   assign left_sel = (total_reg == `TOTAL_1) && (justify_shift_field == `JUSTIFY_LEFT);
   assign shift_amt = justify_shift_field[`JUSTIFY_LEFT_BIT] ? 2'h0 : justify_shift_field[1:0];
   assign formatted = left_sel ? (sum_next << `LEFT_JUSTIFY_SHIFT) : (sum_next >> shift_amt);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= '0;
      end else if (last_conv) begin
         result_reg.result_high_byte <= formatted[15:8];
         result_reg.result_low_byte <= eight_bit_mode_bit ? `LOW_BYTE_ZERO : formatted[7:0];
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 1'b0;
      end else if (last_conv) begin
         flag_reg <= 1'b1;
      end else if (done_flag_clear) begin
         flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg <= 5'h00;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= (div_cnt_reg >= sar_clock_divider_field);
         div_cnt_reg <= (div_cnt_reg >= sar_clock_divider_field) ? 5'h00 : div_cnt_reg + 5'h01;
      end
   end

   // buffer low power passed to core
   // bias and mux fields passed to core
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pcfg_reg <= '0;
      end else begin
         pcfg_reg <= power_control_reg;
      end
   end

   assign core_power_on = burst_mode_enable_bit
      ? ((state_reg != ST_IDLE) || converter_enable_bit) : converter_enable_bit;
   assign ref_power_on = core_power_on && internal_ref_select;
   assign core_start = start_reg;
   assign core_power_cfg = pcfg_reg;
   assign sar_clock_tick = tick_reg;
   assign busy = (state_reg != ST_IDLE) || (count_reg != 7'h00);
   assign conversion_done_flag = flag_reg;
   assign result_word = result_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_flag_after_last: assert property (last_conv |=> conversion_done_flag)
      else $error("done flag not set after last sample");
   chk_set_wins: assert property (last_conv && done_flag_clear |=> conversion_done_flag)
      else $error("flag clear beat a completion");
   chk_right_full: assert property (last_conv && left_sel == 1'b0 && total_reg == `TOTAL_1
      && justify_shift_field == `JUSTIFY_RIGHT && !eight_bit_mode_bit && core_code == 10'h3FF
      |=> result_word == 16'h03FF)
      else $error("right full scale wrong");
   chk_left_full: assert property (last_conv && left_sel && !eight_bit_mode_bit
      && core_code == 10'h3FF |=> result_word == 16'hFFC0)
      else $error("left full scale wrong");
   chk_low_zero_8bit: assert property (last_conv && eight_bit_mode_bit
      |=> result_word.result_low_byte == 8'h00)
      else $error("8-bit low byte not zero");
   chk_shift_truncate: assert property (last_conv && !left_sel && !eight_bit_mode_bit
      |=> result_word == ($past(sum_next) >> $past(shift_amt)))
      else $error("shifted sum wrong");
   chk_result_stable: assert property (!last_conv |=> $stable(result_word))
      else $error("result changed mid-series");
   chk_no_second_powerup: assert property ((state_reg == ST_CONVERT) && core_done
      && !last_conv && burst_mode_enable_bit |=> core_start && (state_reg == ST_CONVERT))
      else $error("power-up repeated in a burst");
   chk_burst_idle_off: assert property (burst_mode_enable_bit && !converter_enable_bit
      && state_reg == ST_IDLE |-> !core_power_on && !ref_power_on)
      else $error("power left on in burst idle");
   chk_acc_cleared: assert property (accept && count_reg == 7'h00 |=> acc_reg == 16'h0000)
      else $error("accumulator not cleared");
   chk_powerup_wait: assert property (accept && need_powerup |=> !core_start [*2])
      else $error("start issued before power-up");

   cov_burst_four: cover property (last_conv && burst_mode_enable_bit && total_reg == `TOTAL_4);
   cov_left_single: cover property (last_conv && left_sel);
   cov_powerup_path: cover property (pu_done);
   cov_set_and_clear: cover property (last_conv && done_flag_clear);
endmodule

// file: verification/tb.sv
// Self-checking bench for the accumulate and format block.
// Plays the analog core and drives every control port itself; no partner model.
`timescale 1ns/1ns
`define CHECK(g, e) cmp(16'(g), 16'(e))
module tb;
   import adc_acc_pkg::*;
   // Short power-up wait keeps the run brief
   localparam int PU = 4;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic en = 1'b1, burst = 1'b0, eightb = 1'b0, ref_sel = 1'b0;
   logic [2:0] rpt = 3'h0, js = 3'h0;
   logic [4:0] div = 5'h01;
   power_cfg_type pcfg = '0;
   logic start = 1'b0, clr = 1'b0, done = 1'b0;
   logic [9:0] code = 10'h000;
   logic core_start, core_power_on, ref_power_on, sar_clock_tick, busy, flag;
   power_cfg_type core_power_cfg;
   result_type result_word;
   int fails = 0;
   int compares = 0;

   always #20 sys_clk = ~sys_clk;

   adc_result_accumulate_format #(.POWERUP_CYCLES(PU)) dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .converter_enable_bit(en),
      .burst_mode_enable_bit(burst), .eight_bit_mode_bit(eightb),
      .internal_ref_select(ref_sel), .repeat_count_field(rpt), .justify_shift_field(js),
      .sar_clock_divider_field(div), .power_control_reg(pcfg), .convert_start(start),
      .done_flag_clear(clr), .core_start(core_start), .core_done(done), .core_code(code),
      .core_power_on(core_power_on), .ref_power_on(ref_power_on),
      .core_power_cfg(core_power_cfg), .sar_clock_tick(sar_clock_tick), .busy(busy),
      .conversion_done_flag(flag), .result_word(result_word));

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Inputs always change one time unit after the rising edge
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask

   // Cycles until core_start is seen; a missing pulse ends the run
   task automatic wait_start(output int n);
      n = 0;
      while (core_start !== 1'b1 && n < 200) begin
         step();
         start = 1'b0;
         n++;
      end
      if (core_start !== 1'b1) begin
         fails++;
         end_of_test();
      end
   endtask

   function automatic logic [15:0] expect_word(int total, logic [9:0] c, logic [2:0] j,
                                               logic e8);
      logic [15:0] s;
      s = 16'(total) * 16'(e8 ? (c & 10'h3FC) : c);
      if (j == 3'h4 && total == 1) s = s << 6;
      else if (j >= 3'h1 && j <= 3'h3) s = s >> j;
      if (e8) s[7:0] = 8'h00;
      return s;
   endfunction

   // One whole series; a second start is poked in mid-burst and must be ignored
   task automatic series(input logic [2:0] r, input logic [2:0] j, input logic b,
                         input logic e, input logic e8, input logic [9:0] c);
      int total, n;
      total = (r == 3'h0 || r > 3'h5) ? 1 : 1 << (r + 1);
      rpt = r; js = j; burst = b; en = e; eightb = e8; code = c;
      clr = 1'b1;
      step();
      clr = 1'b0;
      `CHECK(flag, 1'b0);
      `CHECK(core_power_on, e | !b);
      for (int i = 0; i < total; i++) begin
         if (i == 0 || !b) start = 1'b1;
         wait_start(n);
         `CHECK(n, (i == 0) ? ((b && !e) ? PU + 1 : 1) : (b ? 0 : 1));
         `CHECK(core_power_on, 1'b1);
         `CHECK(ref_power_on, ref_sel);
         if (i == 0 && b) start = 1'b1;
         done = 1'b1;
         step();
         done = 1'b0;
         start = 1'b0;
         if (i < total - 1) `CHECK(flag, 1'b0);
      end
      for (int k = 0; k < 3 && flag !== 1'b1; k++) step();
      `CHECK(flag, 1'b1);
      `CHECK(result_word, expect_word(total, c, j, e8));
      `CHECK(busy, 1'b0);
      `CHECK(core_power_on, e | !b);
      `CHECK(ref_power_on, (e | !b) & ref_sel);
      n = 0;
      repeat (4) begin
         step();
         if (core_start !== 1'b0) n++;
      end
      `CHECK(n, 0);
   endtask

   task automatic t_format();
      series(3'h0, 3'h0, 1'b0, 1'b1, 1'b0, 10'h3FF);
      series(3'h0, 3'h4, 1'b0, 1'b1, 1'b0, 10'h3FF);
      series(3'h0, 3'h4, 1'b0, 1'b1, 1'b0, 10'h100);
      series(3'h0, 3'h0, 1'b0, 1'b1, 1'b1, 10'h3FF);
      series(3'h0, 3'h4, 1'b0, 1'b1, 1'b1, 10'h2FF);
   endtask

   // Repeat codes 1 to 5 in burst with power gating, then each right shift
   task automatic t_repeat();
      for (int r = 1; r <= 5; r++) series(3'(r), 3'h0, 1'b1, 1'b0, 1'b0, 10'h3FF);
      for (int s = 1; s <= 3; s++) series(3'(2 * s - 1), 3'(s), 1'b1, 1'b0, 1'b0, 10'h1FF);
      series(3'h1, 3'h0, 1'b0, 1'b1, 1'b0, 10'h1FF);
      series(3'h2, 3'h0, 1'b1, 1'b1, 1'b0, 10'h201);
   endtask

   task automatic t_tick(input logic [4:0] d);
      int n;
      div = d;
      repeat (8) step();
      n = 0;
      while (sar_clock_tick !== 1'b1 && n < 50) begin
         step();
         n++;
      end
      n = 0;
      do begin
         step();
         n++;
      end while (sar_clock_tick !== 1'b1 && n < 50);
      `CHECK(n, d + 1);
   endtask

   task automatic t_power(input power_cfg_type p);
      pcfg = p;
      repeat (2) step();
      `CHECK(core_power_cfg, p);
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      #1;
      `CHECK(result_word, 16'h0000);
      `CHECK(flag, 1'b0);
      reset_n = 1'b1;
      repeat (3) step();
      ref_sel = 1'b1;
      t_format();
      t_repeat();
      ref_sel = 1'b0;
      series(3'h1, 3'h0, 1'b1, 1'b0, 1'b0, 10'h3FF);
      t_tick(5'h01);
      t_tick(5'h05);
      t_power(4'hB);
      t_power(4'h6);
      end_of_test();
   end
endmodule
